/* File: mr1_ctrl_pkg.sv */
// Constants for the mode register one command controller
// Function
// - First mode register loaded on bank select 001
// - Reserved bank and address bits driven zero
// - Write leveling limits termination unless outputs off
// - Termination during writes limited to divide 2/4/6
// - Wait lock time before read or ODT
// - Clock enable held high during lock time
// - DLL-off: ODT pin low, termination bits zero
// - DLL-off: write termination field cleared
// - DLL enabled at init and return: left to the user, A0 follows dll_disable
// - Controller should support write leveling
package mr1_ctrl_pkg;
  // ----------------------------------------------------------------
  // Command bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] BANK_MR1 = 3'h1;
  localparam logic [2:0] BANK_MR2 = 3'h2;
  localparam int ADDR_W = 16;
  // ----------------------------------------------------------------
  // Mode register one field positions
  // ----------------------------------------------------------------
  localparam int MR1_DLL_OFF = 0;
  localparam int MR1_DRV_LO = 1;
  localparam int MR1_NOM_B0 = 2;
  localparam int MR1_AL_LO = 3;
  localparam int MR1_DRV_HI = 5;
  localparam int MR1_NOM_B1 = 6;
  localparam int MR1_WLEVEL = 7;
  localparam int MR1_NOM_B2 = 9;
  localparam int MR1_TSTROBE = 11;
  localparam int MR1_OUT_OFF = 12;
  // ----------------------------------------------------------------
  // Mode register two field positions
  // ----------------------------------------------------------------
  localparam int MR2_PASR_LO = 0;
  localparam int MR2_CWL_LO = 3;
  localparam int MR2_ASR = 6;
  localparam int MR2_SRT = 7;
  localparam int MR2_WTERM_LO = 9;
  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] AL_RESERVED = 2'h3;
  localparam logic [2:0] NOM_OFF = 3'h0;
  localparam logic [2:0] NOM_DIV4 = 3'h1;
  localparam logic [2:0] NOM_DIV2 = 3'h2;
  localparam logic [2:0] NOM_DIV6 = 3'h3;
  localparam logic [1:0] WTERM_OFF = 2'h0;
  // ----------------------------------------------------------------
  // Timing counts, in clock cycles
  // ----------------------------------------------------------------
  localparam int DLL_LOCK_CYCLES = 512;
  localparam int MRS_GAP_CYCLES = 4;
  localparam int CNT_W = 10;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_GAP = 3'b100
  } seq_state_t;
endpackage

/* File: wait_counter.sv */
// Loadable down counter that reports when its wait has run out
`timescale 1ns/1ns
`default_nettype none
module wait_counter #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // Status
  output logic running
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  assign count_next = load ? load_value :
                      (count_reg != '0) ? count_reg - 1'b1 : count_reg;
  assign running = (count_reg != '0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

/* File: mr1_ctrl.sv */
// Controller that programs mode registers one and two and guards DLL use
`timescale 1ns/1ns
`default_nettype none
module mr1_ctrl
  import mr1_ctrl_pkg::*;
#(
  parameter int LOCK_CYCLES = DLL_LOCK_CYCLES,
  parameter int GAP_CYCLES = MRS_GAP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Requests
  input wire logic mr1_req,
  input wire logic mr2_req,
  input wire logic dll_reset_issued,
  input wire logic cke_req,
  input wire logic odt_req,
  input wire logic read_req,
  // Mode register one settings
  input wire logic dll_disable,
  input wire logic [1:0] drive_sel,
  input wire logic [2:0] nom_term,
  input wire logic [1:0] al_code,
  input wire logic wr_level,
  input wire logic term_strobe_en,
  input wire logic out_disable,
  // Mode register two settings
  input wire logic [2:0] pasr,
  input wire logic [2:0] cwl_code,
  input wire logic asr,
  input wire logic srt,
  input wire logic [1:0] write_term,
  // Answers
  output logic busy,
  output logic done,
  output logic refused,
  output logic dll_ready,
  output logic read_grant,
  // Device command pins
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic [2:0] ba,
  output logic [ADDR_W-1:0] addr,
  output logic cke,
  output logic odt
);
  // ----------------------------------------------------------------
  // Settings checks and word assembly
  // ----------------------------------------------------------------
  seq_state_t state_reg, state_next;
  logic dll_off_reg;
  logic dll_off_next;
  logic lock_running;
  logic gap_running;
  logic nom_restricted;
  logic nom_ok;
  logic nom_in_set;
  logic al_legal;
  logic mr1_bad;
  logic take_mr1;
  logic take_mr2;
  logic take_any;
  logic [2:0] nom_eff;
  logic [1:0] wterm_eff;
  logic [ADDR_W-1:0] mr1_word;
  logic [ADDR_W-1:0] mr2_word;
  logic [ADDR_W-1:0] word_next;
  logic [2:0] bank_next;
  logic gap_load;
  logic lock_start;
  logic [CNT_W-1:0] gap_count;
  logic [CNT_W-1:0] lock_count;
  logic done_next;
  logic refused_next;

  // Termination limits apply to write leveling with outputs on and to writes
  assign nom_restricted = wr_level ? !out_disable : 1'b1;
  assign nom_in_set = (nom_term == NOM_OFF) || (nom_term == NOM_DIV4) ||
                      (nom_term == NOM_DIV2) || (nom_term == NOM_DIV6);
  assign nom_ok = !nom_restricted || nom_in_set;
  // The reserved latency code leaves device timing undefined, so it is refused
  assign al_legal = (al_code != AL_RESERVED);
  assign mr1_bad = !al_legal || !nom_ok;

  // DLL-off cannot use nominal or dynamic termination, so force them off
  assign nom_eff = dll_disable ? NOM_OFF : nom_term;
  assign wterm_eff = dll_off_reg ? WTERM_OFF : write_term;

  always_comb begin
    mr1_word = '0;
    mr1_word[MR1_DLL_OFF] = dll_disable;
    mr1_word[MR1_DRV_LO] = drive_sel[0];
    mr1_word[MR1_DRV_HI] = drive_sel[1];
    mr1_word[MR1_NOM_B0] = nom_eff[0];
    mr1_word[MR1_NOM_B1] = nom_eff[1];
    mr1_word[MR1_NOM_B2] = nom_eff[2];
    mr1_word[MR1_AL_LO +: 2] = al_code;
    mr1_word[MR1_WLEVEL] = wr_level;
    mr1_word[MR1_TSTROBE] = term_strobe_en;
    mr1_word[MR1_OUT_OFF] = out_disable;
  end

  always_comb begin
    mr2_word = '0;
    mr2_word[MR2_PASR_LO +: 3] = pasr;
    mr2_word[MR2_CWL_LO +: 3] = cwl_code;
    mr2_word[MR2_ASR] = asr;
    mr2_word[MR2_SRT] = srt;
    mr2_word[MR2_WTERM_LO +: 2] = wterm_eff;
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // First mode register wins when both are asked for in one cycle
  assign take_mr1 = (state_reg == ST_IDLE) && mr1_req && !mr1_bad;
  assign take_mr2 = (state_reg == ST_IDLE) && mr2_req && !mr1_req;
  assign take_any = take_mr1 || take_mr2;
  assign word_next = take_mr1 ? mr1_word : mr2_word;
  assign bank_next = take_mr1 ? BANK_MR1 : BANK_MR2;
  assign dll_off_next = take_mr1 ? dll_disable : dll_off_reg;

  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = take_any ? ST_ISSUE : ST_IDLE;
      ST_ISSUE: state_next = ST_GAP;
      ST_GAP: state_next = gap_running ? ST_GAP : ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      dll_off_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dll_off_reg <= dll_off_next;
    end
  end

  // Bank and address pins change only when a command is taken, so words stay stable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_b <= 1'b1;
      ras_b <= 1'b1;
      cas_b <= 1'b1;
      we_b <= 1'b1;
      ba <= 3'h0;
      addr <= '0;
    end else begin
      cs_b <= !take_any;
      ras_b <= !take_any;
      cas_b <= !take_any;
      we_b <= !take_any;
      if (take_any) begin
        ba <= bank_next;
        addr <= word_next;
      end
    end
  end

  // A bad request is answered one cycle later, for every cycle it is held while the sequencer is idle
  assign done_next = (state_reg == ST_GAP) && !gap_running;
  assign refused_next = (state_reg == ST_IDLE) && mr1_req && mr1_bad;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
      refused <= 1'b0;
    end else begin
      done <= done_next;
      refused <= refused_next;
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // Loaded as the strobe goes out, one short so the gap spans GAP_CYCLES
  assign gap_load = (state_reg == ST_ISSUE);
  assign gap_count = CNT_W'(GAP_CYCLES - 1);
  // A lock wait only starts while the DLL is on; DLL-off never locks
  assign lock_start = dll_reset_issued && !dll_off_reg;
  assign lock_count = CNT_W'(LOCK_CYCLES);

  wait_counter #(
    .WIDTH(CNT_W)
  ) gap_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(gap_load),
    .load_value(gap_count),
    .running(gap_running)
  );

  wait_counter #(
    .WIDTH(CNT_W)
  ) lock_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(lock_start),
    .load_value(lock_count),
    .running(lock_running)
  );

  // ----------------------------------------------------------------
  // DLL dependent pins
  // ----------------------------------------------------------------
  assign busy = (state_reg != ST_IDLE);
  assign dll_ready = !dll_off_reg && !lock_running;
  assign read_grant = read_req && dll_ready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cke <= 1'b0;
      odt <= 1'b0;
    end else begin
      cke <= cke_req || lock_running;
      odt <= odt_req && dll_ready;
    end
  end
endmodule
`default_nettype wire

/* File: mr1_ctrl_checker.sv */
// Port checks for the mode register controller
`timescale 1ns/1ns
`default_nettype none
module mr1_ctrl_checker
  import mr1_ctrl_pkg::*;
#(
  parameter int LOCK_CYCLES = 8,
  parameter int GAP_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Answers
  input wire logic done,
  input wire logic dll_ready,
  input wire logic read_grant,
  // Command pins
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [2:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic cke,
  input wire logic odt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  wire mr1_cmd = !cs_b && ba == BANK_MR1;
  wire [2:0] nom = {addr[9], addr[6], addr[2]};
  // DLL-off holds the ready flag low with no lock wait, so track it from the words sent
  logic dll_off_seen;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dll_off_seen <= 1'b0;
    end else if (mr1_cmd) begin
      dll_off_seen <= addr[0];
    end
  end
  sequence set_cmd;
    !cs_b && !ras_b && !cas_b && !we_b;
  endsequence
  sequence cmd_end;
    cs_b ##GAP_CYCLES done;
  endsequence
  cmd_shape_a: assert property (!cs_b |-> set_cmd ##1 cmd_end)
    else $error("command strobes or done timing wrong");
  rsvd_zero_a: assert property (mr1_cmd |-> !ba[2] && !addr[8] && !addr[10] && addr[15:13] == 0)
    else $error("reserved bits set in register one word");
  al_legal_a: assert property (mr1_cmd |-> addr[4:3] != AL_RESERVED)
    else $error("reserved additive latency code sent");
  nom_limit_a: assert property (mr1_cmd && !(addr[7] && addr[12]) |-> nom <= NOM_DIV6)
    else $error("termination code outside allowed set");
  dll_off_nom_a: assert property (mr1_cmd && addr[0] |-> nom == NOM_OFF)
    else $error("termination left on with DLL off");
  odt_lock_a: assert property (odt |-> $past(dll_ready))
    else $error("odt raised during lock wait");
  grant_lock_a: assert property (read_grant |-> dll_ready)
    else $error("read granted during lock wait");
  lock_cke_a: assert property (!dll_off_seen && !dll_ready && !$past(dll_ready) && !$past(dll_ready, 2) |-> cke)
    else $error("clock enable low during lock wait");
endmodule
`default_nettype wire

/* File: mode_reg_device.sv */
// Behavioural memory device holding mode registers one and two
`timescale 1ns/1ns
`default_nettype none
module mode_reg_device #(
  parameter int CAS_LAT = 6
) (
  // Clock and command pins
  input wire logic clk,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  // Stored words
  output logic [15:0] mr1_reg,
  output logic [15:0] mr2_reg
);
  wire load = !cs_b && !ras_b && !cas_b && !we_b;
  wire [1:0] drive_code = {mr1_reg[5], mr1_reg[1]};
  wire [1:0] alc = mr1_reg[4:3];
  // Reserved code leaves latency unknown on purpose
  wire [4:0] add_lat = alc == 2'h0 ? 5'h0 : alc == 2'h1 ? 5'(CAS_LAT - 1) :
    alc == 2'h2 ? 5'(CAS_LAT - 2) : 5'hx;
  wire [4:0] read_lat = add_lat + 5'(CAS_LAT);
  wire [4:0] write_lat = add_lat + 5'(mr2_reg[5:3]) + 5'h5;
  wire mask_en = !mr1_reg[11];
  wire outs_off = mr1_reg[12];
  // Writes lean on the DLL only while write termination is set
  wire wr_needs_dll = mr2_reg[10:9] != 2'h0;
  // Self-refresh and the DLL reset bit are not modelled; DLL state follows A0
  wire dll_on = !mr1_reg[0];
  initial begin
    mr1_reg = 16'h0;
    mr2_reg = 16'h0;
  end
  always @(posedge clk) begin
    if (load && ba == 3'h1)
      mr1_reg <= addr;
    if (load && ba == 3'h2)
      mr2_reg <= addr;
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the mode register controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mr1_ctrl_pkg::*;
  localparam int LOCK_C = 8;
  logic clk, rst_b, mr1_req, mr2_req, dll_rst, cke_req, odt_req, read_req;
  logic dll_dis, wr_lvl, ts_en, o_dis, asr, srt, busy, done, refused, dll_ready, read_grant;
  logic cs_b, ras_b, cas_b, we_b, cke, odt;
  logic [1:0] drv, al, wterm;
  logic [2:0] nom, pasr, cas_write_latency, ba;
  logic [15:0] addr, mr1_reg, mr2_reg;
  int mismatches = 0;
  int total_checks = 0;
  mr1_ctrl #(.LOCK_CYCLES(LOCK_C)) u_dut (.clk(clk), .rst_b(rst_b), .mr1_req(mr1_req),
    .mr2_req(mr2_req), .dll_reset_issued(dll_rst), .cke_req(cke_req), .odt_req(odt_req),
    .read_req(read_req), .dll_disable(dll_dis), .drive_sel(drv), .nom_term(nom),
    .al_code(al), .wr_level(wr_lvl), .term_strobe_en(ts_en), .out_disable(o_dis),
    .pasr(pasr), .cwl_code(cas_write_latency), .asr(asr), .srt(srt), .write_term(wterm), .busy(busy),
    .done(done), .refused(refused), .dll_ready(dll_ready), .read_grant(read_grant),
    .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr),
    .cke(cke), .odt(odt));
  mode_reg_device u_mem (.clk(clk), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
    .we_b(we_b), .ba(ba), .addr(addr), .mr1_reg(mr1_reg), .mr2_reg(mr2_reg));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic set1(input logic dd, input logic [1:0] d, input logic [2:0] nm,
      input logic [1:0] a, input logic w, t, o);
    {dll_dis, drv, nom, al, wr_lvl, ts_en, o_dis} = {dd, d, nm, a, w, t, o};
  endtask
  // Holds the request until taken or refused, then checks the stored word
  task automatic prog(input logic two, input logic ok, input logic [15:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    mr1_req = !two;
    mr2_req = two;
    do begin
      @(negedge clk);
      n++;
    end while (!busy && !refused && n < 20);
    mr1_req = 1'b0;
    mr2_req = 1'b0;
    chk(16'({busy, refused}), ok ? 16'h0002 : 16'h0001);
    n = 0;
    while (ok && !done && n < 20) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    chk(two ? mr2_reg : mr1_reg, exp);
  endtask
  task automatic t_fields;
    logic [15:0] w, last;
    last = 16'h0;
    for (int i = 0; i < 8; i++) begin
      set1(1'b0, 2'(i), 3'(i), 2'(i), 1'b0, 1'b0, 1'b0);
      w = 16'(i[2]) << 9 | 16'(i[1]) << 6 | 16'(i[0]) << 2 | 16'(i[1:0]) << 3;
      w = w | 16'(i[1]) << 5 | 16'(i[0]) << 1;
      if (i < 3)
        last = w;
      prog(1'b0, i < 3, last);
    end
    set1(1'b0, 2'h0, 3'h5, 2'h0, 1'b1, 1'b0, 1'b1);
    prog(1'b0, 1'b1, 16'h1284);
    o_dis = 1'b0;
    prog(1'b0, 1'b0, 16'h1284);
    set1(1'b0, 2'h2, 3'h3, 2'h2, 1'b0, 1'b1, 1'b0);
    prog(1'b0, 1'b1, 16'h0874);
    $display("field test over");
  endtask
  task automatic t_dll_off;
    set1(1'b1, 2'h0, 3'h2, 2'h0, 1'b0, 1'b0, 1'b0);
    prog(1'b0, 1'b1, 16'h0001);
    {pasr, cas_write_latency, asr, srt, wterm} = {3'h1, 3'h3, 1'b1, 1'b1, 2'h2};
    prog(1'b1, 1'b1, 16'h00d9);
    dll_rst = 1'b1;
    @(negedge clk);
    dll_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(16'({dll_ready, cke}), 16'h0);
    set1(1'b0, 2'h0, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    prog(1'b0, 1'b1, 16'h0000);
    prog(1'b1, 1'b1, 16'h04d9);
    $display("dll off test over");
  endtask
  task automatic t_lock;
    int n;
    n = 0;
    {cke_req, odt_req, read_req} = 3'b011;
    dll_rst = 1'b1;
    @(negedge clk);
    dll_rst = 1'b0;
    while (dll_ready && n < 4) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk(16'({cke, odt, read_grant}), 16'h4);
    n = 0;
    while (!dll_ready && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n >= LOCK_C - 3 && n <= LOCK_C), 16'h1);
    @(negedge clk);
    chk(16'({odt, read_grant}), 16'h3);
    $display("lock test over");
  endtask
  initial begin
    {mr1_req, mr2_req, dll_rst, cke_req, odt_req, read_req} = '0;
    {pasr, cas_write_latency, asr, srt, wterm} = '0;
    set1(1'b0, 2'h0, 3'h0, 2'h0, 1'b0, 1'b0, 1'b0);
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk(16'({cs_b, ras_b, cas_b, we_b, cke, dll_ready}), 16'h3d);
    t_fields();
    t_dll_off();
    t_lock();
    give_verdict();
  end
  // Whole run needs under 2000 cycles
  initial begin
    #(20000 * 8);
    mismatches++;
    give_verdict();
  end
endmodule
bind mr1_ctrl mr1_ctrl_checker #(.LOCK_CYCLES(LOCK_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_chk (
  .clk(clk), .rst_b(rst_b), .done(done), .dll_ready(dll_ready), .read_grant(read_grant),
  .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .ba(ba), .addr(addr),
  .cke(cke), .odt(odt));
`default_nettype wire
